// *** core/sac_pkg.sv ***
// Shared constants and types of the converter control block
package sac_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_MUX = 5'h00;
  localparam logic [4:0] OFF_CTL = 5'h04;
  localparam logic [4:0] OFF_RES_LO = 5'h08;
  localparam logic [4:0] OFF_RES_HI = 5'h0C;
  localparam logic [4:0] OFF_TRIG = 5'h10;
  localparam logic [7:0] RST_MUX = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [2:0] RST_TRIG = 3'h0;
  localparam logic [9:0] RST_RES = 10'h000;
  // mux_select fields
  localparam int MUX_REF_HI = 7;
  localparam int MUX_REF_LO = 6;
  localparam int MUX_LEFT = 5;
  localparam int MUX_UNUSED = 4;
  localparam int MUX_CH_HI = 3;
  localparam int MUX_CH_LO = 0;
  // conv_control_a fields
  localparam int CTL_EN = 7;
  localparam int CTL_START = 6;
  localparam int CTL_ATE = 5;
  localparam int CTL_FLAG = 4;
  localparam int CTL_IE = 3;
  localparam int CTL_PS_HI = 2;
  localparam int CTL_PS_LO = 0;
  // Reference codes
  localparam logic [1:0] REF_EXT_PIN = 2'h0;
  localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  // Channel codes beyond the eight inputs
  localparam logic [3:0] CH_LAST_INPUT = 4'h7;
  localparam logic [3:0] CH_BANDGAP = 4'hE;
  localparam logic [3:0] CH_GROUND = 4'hF;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  // Conversion lengths in converter clocks
  localparam logic [4:0] FIRST_CONV_CYC = 5'd25;
  localparam logic [4:0] NORMAL_CONV_CYC = 5'd13;
  localparam logic [4:0] SAR_CYC = 5'd10;
  localparam logic [9:0] SAR_MID = 10'h200;
  localparam int PS_W = 7;

  typedef enum logic {SAC_IDLE, SAC_CONV} sac_state_t;

  typedef struct packed {
    logic power;
    logic [1:0] ref_sel;
    logic [3:0] channel;
    logic sample;
    logic [9:0] dac;
  } sac_ana_t;
endpackage : sac_pkg

// *** core/sac_prescaler.sv ***
// Converter clock enable generator
`timescale 1ns/10ps
`default_nettype none
module sac_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  import sac_pkg::*;

  logic [sac_pkg::PS_W-1:0] cnt_q;
  logic [sac_pkg::PS_W-1:0] cnt_d;
  logic [sac_pkg::PS_W-1:0] last;

  // Divisor minus one; codes 0 and 1 both divide by two
  function automatic logic [PS_W-1:0] div_last(input logic [2:0] s);
    logic [PS_W:0] d;
    d = (s == 3'h0) ? 8'h02 : (8'h01 << s);
    return d[PS_W-1:0] - 7'h01;
  endfunction : div_last

  assign last = div_last(div_sel);
  assign tick = run && (cnt_q == last);
  assign cnt_d = (!run || tick) ? 7'h00 : cnt_q + 7'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("converter clock enable on two adjacent cycles");

  property p_no_tick_off;
    @(posedge pclk) disable iff (!presetn)
    !run |-> !tick;
  endproperty
  a_no_tick_off: assert property (p_no_tick_off)
    else $error("converter clock enable while disabled");
endmodule : sac_prescaler
`default_nettype wire

// *** core/sac_top.sv ***
// Register file and conversion sequencer of the 10-bit converter
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
//
// Behaviour
// - Unsigned 10-bit code, zero is ground
// - Reference field picks pin, supply or internal
// - Selection changes wait until conversion completes
// - Alignment bit changes result layout immediately
// - Unused mux bit always reads zero
// - Channel field picks inputs, bandgap or ground
// - Enable bit on; clearing aborts conversion
// - First conversion 25 clocks, later ones 13
// - Start bit reads one while busy; zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag set when result registers update
// - Flag cleared by vector taken or one
// - Interrupt needs flag, enable and global enable
// - Prescaler divides by 2,2,4 up to 128
// - Right aligned: high holds bits 9:8
// - Left aligned: high holds bits 9:2
// - Low read freezes results until high read
// - Code zero free-runs; switching adds no trigger
module sac_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sac_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:1] trig_src,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic irq,
  input wire logic cmp_high,
  output sac_pkg::sac_ana_t ana
);
  import sac_pkg::*;

  logic [7:0] mux_q;
  logic en_q;
  logic ate_q;
  logic ie_q;
  logic [2:0] ps_q;
  logic flag_q;
  logic flag_d;
  logic [2:0] ts_q;
  sac_state_t state_q;
  logic pend_q;
  logic first_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  logic [3:0] bit_q;
  logic [9:0] dac_q;
  logic [9:0] res_q;
  logic hold_q;
  logic [5:0] lock_q;
  logic trig_prev_q;
  logic [31:0] prdata_q;

  logic tick;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic wr_lane;
  logic sel_mux;
  logic sel_ctl;
  logic sel_lo;
  logic sel_hi;
  logic sel_trig;
  logic mapped;
  logic [7:0] wdat;
  logic [7:0] ctl_rd;
  logic [7:0] mux_rd;
  logic [7:0] res_lo_rd;
  logic [7:0] res_hi_rd;
  logic [7:0] rd_mux;
  logic busy;
  logic start_sw;
  logic trig_sel;
  logic trig_rise;
  logic done;
  logic update;
  logic start_auto;
  logic start_now;
  logic in_sar;
  logic sar_begin;
  logic en_next;
  logic [5:0] sel_now;

  // Register decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign wr_lane = wr && pstrb[0];
  assign wdat = pwdata[7:0];
  assign sel_mux = (paddr == OFF_MUX);
  assign sel_ctl = (paddr == OFF_CTL);
  assign sel_lo = (paddr == OFF_RES_LO);
  assign sel_hi = (paddr == OFF_RES_HI);
  assign sel_trig = (paddr == OFF_TRIG);
  assign mapped = sel_mux || sel_ctl || sel_lo || sel_hi || sel_trig;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  assign busy = (state_q == SAC_CONV);
  assign mux_rd = {mux_q[7:5], 1'b0, mux_q[3:0]};
  assign ctl_rd = {en_q, busy || pend_q, ate_q, flag_q, ie_q, ps_q};
  // Presentation follows the alignment bit live
  assign res_hi_rd = mux_q[MUX_LEFT] ? res_q[9:2]
                                     : {6'h00, res_q[9:8]};
  assign res_lo_rd = mux_q[MUX_LEFT] ? {res_q[1:0], 6'h00}
                                     : res_q[7:0];
  assign rd_mux = sel_mux ? mux_rd :
                  sel_ctl ? ctl_rd :
                  sel_lo ? res_lo_rd :
                  sel_hi ? res_hi_rd :
                  sel_trig ? {5'h00, ts_q} : 8'h00;

  // Control writes
  assign en_next = (wr_lane && sel_ctl) ? wdat[CTL_EN] : en_q;
  assign start_sw = wr_lane && sel_ctl && wdat[CTL_START]
                    && wdat[CTL_EN];

  // Trigger path
  assign trig_sel = (ts_q == TRIG_FREE_RUN) ? 1'b0
                                            : trig_src[ts_q];
  assign trig_rise = trig_sel && !trig_prev_q;
  // Free-running re-arms at completion, edges only when idle
  assign start_auto = en_q && ate_q
                      && ((ts_q != TRIG_FREE_RUN)
                          ? (trig_rise && !busy && !pend_q)
                          : done);

  // Sequencer timing
  assign start_now = tick && pend_q && !busy;
  assign done = busy && tick && (cnt_q == len_q - 5'd1);
  assign update = done && !hold_q;
  assign sar_begin = busy && tick
                     && (cnt_q == len_q - SAR_CYC - 5'd2);
  assign in_sar = busy && (cnt_q >= len_q - SAR_CYC - 5'd1)
                  && (cnt_q < len_q - 5'd1);

  // Selection is transparent when idle, frozen while busy
  assign sel_now = busy ? lock_q : {mux_q[7:6], mux_q[3:0]};

  assign ana.power = en_q;
  assign ana.ref_sel = sel_now[5:4];
  assign ana.channel = sel_now[3:0];
  assign ana.sample = busy && !in_sar;
  assign ana.dac = dac_q;

  assign flag_d = update || (flag_q && !(irq_vector_taken
                  || (wr_lane && sel_ctl && wdat[CTL_FLAG])));
  assign irq = flag_q && ie_q && global_irq_enable;

  sac_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .run(en_q),
    .div_sel(ps_q),
    .tick(tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_q <= RST_MUX;
      {en_q, ate_q, ie_q} <= 3'h0;
      ps_q <= RST_CTL[CTL_PS_HI:CTL_PS_LO];
      ts_q <= RST_TRIG;
      flag_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      trig_prev_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      trig_prev_q <= trig_sel;
      if (setup && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_mux};
      end
      if (wr_lane && sel_mux) begin
        mux_q <= {wdat[7:5], 1'b0, wdat[3:0]};
      end
      if (wr_lane && sel_trig) begin
        ts_q <= wdat[2:0];
      end
      if (wr_lane && sel_ctl) begin
        en_q <= wdat[CTL_EN];
        ate_q <= wdat[CTL_ATE];
        ie_q <= wdat[CTL_IE];
        ps_q <= wdat[CTL_PS_HI:CTL_PS_LO];
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SAC_IDLE;
      pend_q <= 1'b0;
      first_q <= 1'b1;
      cnt_q <= 5'd0;
      len_q <= NORMAL_CONV_CYC;
      lock_q <= 6'h00;
      bit_q <= 4'h0;
      dac_q <= 10'h000;
    end else if (!en_next) begin
      state_q <= SAC_IDLE;
      pend_q <= 1'b0;
      first_q <= 1'b1;
      cnt_q <= 5'd0;
    end else begin
      if (start_sw || start_auto) begin
        pend_q <= 1'b1;
      end else if (start_now) begin
        pend_q <= 1'b0;
      end
      if (start_now) begin
        state_q <= SAC_CONV;
        cnt_q <= 5'd0;
        len_q <= first_q ? FIRST_CONV_CYC : NORMAL_CONV_CYC;
        first_q <= 1'b0;
        lock_q <= {mux_q[7:6], mux_q[3:0]};
        dac_q <= 10'h000;
      end else if (done) begin
        state_q <= SAC_IDLE;
        cnt_q <= 5'd0;
      end else if (busy && tick) begin
        cnt_q <= cnt_q + 5'd1;
        if (sar_begin) begin
          dac_q <= SAR_MID;
          bit_q <= 4'd9;
        end else if (in_sar) begin
          dac_q[bit_q] <= cmp_high;
          if (bit_q != 4'd0) begin
            dac_q[bit_q - 4'd1] <= 1'b1;
          end
          bit_q <= bit_q - 4'd1;
        end
      end
    end
  end

  // Result registers and read pairing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= RST_RES;
      hold_q <= 1'b0;
    end else begin
      if (update) begin
        res_q <= dac_q;
      end
      if (rd && sel_hi) begin
        hold_q <= 1'b0;
      end else if (rd && sel_lo) begin
        hold_q <= 1'b1;
      end
    end
  end

  // Checks on the sequencer and register file
  logic [4:0] h_ticks_q;
  logic h_first_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_ticks_q <= 5'd0;
      h_first_q <= 1'b0;
    end else if (start_now) begin
      h_ticks_q <= 5'd1;
      h_first_q <= first_q;
    end else if (busy && tick) begin
      h_ticks_q <= h_ticks_q + 5'd1;
    end
  end

  property p_len;
    @(posedge pclk) disable iff (!presetn)
    done && en_next |-> h_ticks_q == (h_first_q ? 5'd25 : 5'd13);
  endproperty
  a_len: assert property (p_len)
    else $error("conversion length wrong");

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    busy && $past(busy) |-> $stable(ana.channel) && $stable(ana.ref_sel);
  endproperty
  a_lock: assert property (p_lock)
    else $error("selection changed during conversion");

  property p_unused;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_mux |=> prdata[MUX_UNUSED] == 1'b0;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused mux bit read as one");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
    wr_lane && sel_ctl && !wdat[CTL_EN] |=> !busy && !pend_q;
  endproperty
  a_abort: assert property (p_abort)
    else $error("conversion survived disable");

  property p_busy_reads;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_ctl && busy |=> prdata[CTL_START];
  endproperty
  a_busy_reads: assert property (p_busy_reads)
    else $error("start bit read zero while busy");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    update |=> flag_q && res_q == $past(dac_q);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag or result not updated at completion");

  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn)
    flag_q && !update && irq_vector_taken |=> !flag_q;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag survived vector taken");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    $rose(irq) |-> flag_q && ie_q && global_irq_enable;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without its conditions");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    hold_q && !(rd && sel_hi) |=> $stable(res_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result changed between low and high read");

  property p_right;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_hi && !mux_q[MUX_LEFT] |=> prdata[7:2] == 6'h00;
  endproperty
  a_right: assert property (p_right)
    else $error("right aligned high register has upper bits");
endmodule : sac_top
`default_nettype wire

// *** tb/sac_ana_model.sv ***
// Analog input mux and comparator model facing the converter block
`timescale 1ns/10ps
`default_nettype none
module sac_ana_model (
  input wire logic pclk,
  input wire sac_pkg::sac_ana_t ana,
  input wire logic [9:0] vin,
  output logic cmp_high
);
  import sac_pkg::*;
  logic [9:0] held_q;
  logic tgl_q = 1'b0;
  // Sample and hold follows the routed input while sampling
  always @(posedge pclk) begin
    tgl_q <= ~tgl_q;
    if (ana.sample && ana.channel == CH_GROUND) held_q <= 10'h000;
    else if (ana.sample) held_q <= vin + 10'(ana.channel);
  end
  // Unpowered comparator toggles instead of holding a value
  assign cmp_high = ana.power ? (held_q >= ana.dac) : tgl_q;
endmodule : sac_ana_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sac_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic global_irq_enable, irq_vector_taken, irq, cmp_high, left;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [3:0] pstrb, ch;
  logic [7:1] trig_src;
  logic [9:0] vin;
  sac_ana_t ana;
  int n_mismatch, tests_run, cyc, t0;
  int now = 0;

  sac_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_src(trig_src), .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .irq(irq), .cmp_high(cmp_high),
    .ana(ana));
  sac_ana_model u_ana (.pclk(pclk), .ana(ana), .vin(vin),
    .cmp_high(cmp_high));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) now <= now + 1;

  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : step

  // Expected result register for current channel and alignment
  function automatic logic [31:0] exp_res(input logic hi, input logic la);
    logic [9:0] c;
    c = (ch == CH_GROUND) ? 10'h000 : vin + 10'(ch);
    if (la) return hi ? {24'h0, c[9:2]} : {24'h0, c[1:0], 6'h00};
    return hi ? {30'h0, c[9:8]} : {24'h0, c[7:0]};
  endfunction : exp_res

  task automatic tally_and_finish(input int extra);
    n_mismatch += extra;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) tally_and_finish(1);
  endtask : apb

  task automatic wait_irq(input int lim);
    cyc = 0;
    do begin
      @(negedge pclk);
      cyc++;
      if (cyc > lim) tally_and_finish(1);
    end while (irq !== 1'b1);
  endtask : wait_irq

  // Single conversion with a selection change while it runs
  task automatic conv(input int len, input logic [2:0] ps, input logic vec);
    int div;
    int d;
    div = (ps == 3'h0) ? 2 : (1 << ps);
    apb(1'b1, OFF_MUX, {2'b01, left, 1'b0, ch});
    apb(1'b1, OFF_CTL, {5'b11001, ps});
    t0 = now;
    repeat (div + 2) @(negedge pclk);
    apb(1'b1, OFF_MUX, {2'b11, left, 1'b1, ~ch});
    @(negedge pclk);
    chk("locked sel", {2'b01, ch}, {ana.ref_sel, ana.channel});
    wait_irq(30000);
    d = now - t0;
    chk("duration", 1, d >= (len - 1) * div
        && d <= (len + 1) * div + 4);
    apb(1'b0, OFF_RES_LO, 8'h00);
    chk("result_low", exp_res(1'b0, left), rd);
    apb(1'b0, OFF_RES_HI, 8'h00);
    chk("result_high", exp_res(1'b1, left), rd);
    apb(1'b1, OFF_MUX, {2'b11, ~left, 1'b1, ~ch});
    apb(1'b0, OFF_RES_HI, 8'h00);
    chk("realigned", exp_res(1'b1, ~left), rd);
    apb(1'b0, OFF_MUX, 8'h00);
    chk("mux_select", {2'b11, ~left, 1'b0, ~ch}, rd);
    apb(1'b1, OFF_CTL, {5'b10001, ps});
    apb(1'b0, OFF_CTL, 8'h00);
    chk("flag kept", {5'b10011, ps}, rd);
    chk("irq", 1, irq);
    @(posedge pclk);
    global_irq_enable <= 1'b0;
    @(negedge pclk);
    chk("irq masked", 0, irq);
    @(posedge pclk);
    global_irq_enable <= 1'b1;
    if (vec) begin
      irq_vector_taken <= 1'b1;
      @(posedge pclk);
      irq_vector_taken <= 1'b0;
    end else apb(1'b1, OFF_CTL, {5'b10011, ps});
    apb(1'b0, OFF_CTL, 8'h00);
    chk("flag clear", {5'b10001, ps}, rd);
  endtask : conv

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    trig_src = '0;
    global_irq_enable = 1'b1;
    irq_vector_taken = 1'b0;
    vin = '0;
    ch = '0;
    left = 1'b0;
    rnd = 32'hB6B7;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      apb(1'b0, 5'(a * 4), 8'h00);
      chk("reset value", 0, rd);
      chk("slave error", a == 5, err);
    end
    for (int p = 0; p < 8; p++) begin
      apb(1'b1, OFF_CTL, 8'h00);
      for (int n = 0; n < 2; n++) begin
        rnd = step(rnd);
        vin = rnd[9:0];
        ch = rnd[15:12];
        if (ch[3] && ch != CH_BANDGAP) ch = CH_GROUND;
        if (p < 2 && n == 0) ch = 4'h0;
        if (p < 2 && n == 0) vin = p ? 10'h000 : 10'h3FF;
        left = rnd[20];
        conv(n ? 13 : 25, 3'(p), rnd[24]);
      end
    end
    apb(1'b1, OFF_CTL, 8'hC7);
    apb(1'b0, OFF_CTL, 8'h00);
    chk("busy start", 8'hC7, rd);
    apb(1'b1, OFF_CTL, 8'h00);
    repeat (3500) @(negedge pclk);
    apb(1'b0, OFF_CTL, 8'h00);
    chk("aborted", 8'h00, rd);
    chk("power off", 0, ana.power);
    apb(1'b1, OFF_TRIG, 8'h03);
    apb(1'b1, OFF_CTL, 8'hA8);
    t0 = now;
    trig_src[3] <= 1'b1;
    wait_irq(200);
    chk("trig start", 1, now - t0 <= 60);
    apb(1'b1, OFF_CTL, 8'hB8);
    repeat (150) @(negedge pclk);
    chk("no edge", 0, irq);
    apb(1'b1, OFF_TRIG, 8'h00);
    repeat (150) @(negedge pclk);
    chk("switch free", 0, irq);
    apb(1'b1, OFF_CTL, 8'hE8);
    wait_irq(200);
    apb(1'b1, OFF_CTL, 8'hB8);
    apb(1'b0, OFF_CTL, 8'h00);
    chk("free busy", 8'hE8, rd);
    wait_irq(200);
    chk("free rearm", 1, irq);
    tally_and_finish(0);
  end
endmodule : tb
`default_nettype wire
